// ==== rtl/spi_slave_pkg.sv ====
// constants, carriers and contract list for the serial controller spi slave
// Contract
// - SPI function is active only while the mode field holds 2.
// - Every character is exactly 8 bits in both directions.
// - Slave operation applies whenever master select is zero in SPI mode.
// - Clock comes from the master; up to 5 Mbps, master must not exceed it; the bench master runs at 12.5 Mbps.
// - All four clock polarity and phase combinations are supported.
// - Bit order 0 shifts MSB first, 1 shifts LSB first.
// - Polarity 1 to 0 without mode reset emits an extra 0xFE first.
// - While selected, drive MISO and capture MOSI.
// - Select gates MISO driver; deselect resets the shift register.
// - Separate 4-byte transmit and receive FIFOs, reached by software or DMA.
// - Receive valid is set while the receive FIFO is not empty.
// - Character arriving at full receive FIFO is dropped; overflow and overrun flag set.
// - Receive DMA reports overrun only after the receive FIFO drains.
// - DMA error clears on channel reset bit or buffer reload after unload.
// - Each character shifts a transmit byte; empty FIFO sets underrun flag.
// - Underrun sends last byte or 0xFF per repeat select.
// - During underrun transmit idle clears per byte, sets after it with idle flag.
// - Write into empty transmit FIFO changes neither status nor flags.
// - Idle clears after first bit out; sets when FIFO empty and last byte shifted.
// - Transmit free clears when FIFO full, sets when one byte moves out.
// - After select and receive valid once, data into empty FIFO gets one padding byte.
// - Sending the padding byte sets the underrun flag.
// - Events on rising idle, free, receive valid, plus overrun and underrun.
// - Falling DMA buffer active bits raise completion events.
// - Interrupt needs both controller mask and top-level mask enabled.
package spi_slave_pkg;

    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_SPI      = 2'h2;
    localparam int         CHAR_BITS     = 8;
    localparam int         FIFO_DEPTH    = 4;
    localparam logic [2:0] FIFO_FULL_CNT = 3'h4;
    localparam logic [2:0] LAST_BIT_IDX  = 3'h7;
    localparam logic [7:0] BUSY_BYTE     = 8'hff;
    localparam logic [7:0] POL_SWAP_BYTE = 8'hfe;
    localparam logic [7:0] SR_RESET      = 8'h00;
    localparam int         CLK_HZ        = 100_000_000;
    localparam int         MAX_RATE_BPS  = 5_000_000;
    // shortest legal serial clock half period in core clock cycles
    localparam int         MIN_HALF_CYC  = CLK_HZ / (2 * MAX_RATE_BPS);

    typedef struct packed {
        logic master_select_bit;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic bit_order_bit;
        logic repeat_select_bit;
    } spi_cfg_t;

    typedef struct packed {
        logic transmit_idle_status;
        logic transmit_free_status;
        logic receive_valid_status;
        logic receive_overflow_status;
    } spi_status_t;

    // one bit per interrupt source, used for flags, clears and masks alike
    typedef struct packed {
        logic transmit_idle_irq_flag;
        logic transmit_free_irq_flag;
        logic receive_valid_irq_flag;
        logic receive_overrun_irq_flag;
        logic transmit_underrun_irq_flag;
        logic tx_dma_done_irq_flag;
        logic rx_dma_done_irq_flag;
    } irq_vec_t;

    localparam spi_status_t STATUS_RESET = 4'hc;
    localparam irq_vec_t    IRQ_NONE     = 7'h00;

endpackage

// ==== rtl/spi_slave_serial_controller.sv ====
// spi slave mode of the second serial controller with fifos, status and events
`timescale 1ns/1ns
module spi_slave_serial_controller (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // configuration
    input  wire logic [1:0]                controller_mode_field,
    input  wire spi_slave_pkg::spi_cfg_t   spi_config_register,
    input  wire spi_slave_pkg::irq_vec_t   controller_irq_mask_register,
    input  wire logic                      top_irq_mask_bit,
    input  wire spi_slave_pkg::irq_vec_t   irq_flag_clear,
    // transmit fifo write side
    input  wire logic                      tx_wr_valid,
    input  wire logic [7:0]                tx_wr_data,
    output logic                           tx_wr_ready,
    // receive fifo read side
    input  wire logic                      rx_rd_en,
    output logic [7:0]                     rx_rd_data,
    // dma handshakes
    input  wire logic [1:0]                dma_channel_reset_bits,
    input  wire logic [1:0]                tx_buffer_active_bits,
    input  wire logic [1:0]                rx_buffer_active_bits,
    input  wire logic                      tx_buffer_reload,
    input  wire logic                      rx_buffer_reload,
    output logic                           tx_dma_error,
    output logic                           rx_dma_error,
    // status, flags and interrupt
    output spi_slave_pkg::spi_status_t     spi_status_register,
    output spi_slave_pkg::irq_vec_t        controller_irq_flag_register,
    output logic                           irq,
    // spi pins
    input  wire logic                      serial_clock_pin,
    input  wire logic                      slave_select_n,
    input  wire logic                      mosi,
    output logic                           miso_o,
    output logic                           miso_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] sclk_sync_ff, ssn_sync_ff, mosi_sync_ff;
    logic       sclk_q_ff, ssn_q_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_ff <= 2'h0;
            ssn_sync_ff  <= 2'h3;
            mosi_sync_ff <= 2'h0;
            sclk_q_ff    <= 1'b0;
            ssn_q_ff     <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], serial_clock_pin};
            ssn_sync_ff  <= {ssn_sync_ff[0], slave_select_n};
            mosi_sync_ff <= {mosi_sync_ff[0], mosi};
            sclk_q_ff    <= sclk_sync_ff[1];
            ssn_q_ff     <= ssn_sync_ff[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // edge decode
    localparam int FIFO_DEPTH_L = spi_slave_pkg::FIFO_DEPTH;
    spi_slave_pkg::spi_cfg_t cfg;
    logic [2:0] bit_cnt_ff, tx_cnt_ff, rx_cnt_ff;
    logic [1:0] tx_rptr_ff, tx_wptr_ff, rx_rptr_ff, rx_wptr_ff;
    logic [7:0] tx_mem [FIFO_DEPTH_L];
    logic [7:0] rx_mem [FIFO_DEPTH_L];
    logic [7:0] tx_sr_ff, rx_sr_ff, last_ff;
    logic       fe_pend_ff, pad_win_ff, pad_pend_ff, pol_q_ff;

    assign cfg = spi_config_register;

    wire spi_on    = (controller_mode_field == spi_slave_pkg::MODE_SPI) && !cfg.master_select_bit;
    wire selected  = spi_on && !ssn_sync_ff[1];
    wire sel_start = spi_on && ssn_q_ff && !ssn_sync_ff[1];
    wire sclk_rise = sclk_sync_ff[1] && !sclk_q_ff;
    wire sclk_fall = !sclk_sync_ff[1] && sclk_q_ff;
    wire lead_e    = selected && (cfg.clock_polarity_bit ? sclk_fall : sclk_rise);
    wire trail_e   = selected && (cfg.clock_polarity_bit ? sclk_rise : sclk_fall);
    wire sample_e  = cfg.clock_phase_bit ? trail_e : lead_e;
    wire shift_e   = cfg.clock_phase_bit ? lead_e : trail_e;
    wire char_done = sample_e && (bit_cnt_ff == spi_slave_pkg::LAST_BIT_IDX);
    wire load_e    = cfg.clock_phase_bit ? (lead_e && bit_cnt_ff == 3'h0)
                                         : (sel_start || (char_done && selected));
    // the edge after a finished character must not shift the byte just loaded
    wire tx_shift  = shift_e && !load_e && (bit_cnt_ff != 3'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // transmit byte selection
    wire       tx_empty  = (tx_cnt_ff == 3'h0);
    wire       rx_full   = (rx_cnt_ff == spi_slave_pkg::FIFO_FULL_CNT);
    wire [7:0] pad_byte  = cfg.repeat_select_bit ? last_ff : spi_slave_pkg::BUSY_BYTE;
    wire       use_fill  = !fe_pend_ff && (pad_pend_ff || tx_empty);
    wire [7:0] load_byte = fe_pend_ff ? spi_slave_pkg::POL_SWAP_BYTE
                         : use_fill  ? pad_byte : tx_mem[tx_rptr_ff];
    wire       pop_tx    = load_e && !fe_pend_ff && !use_fill;
    wire       underrun  = load_e && use_fill;
    wire       push_tx   = tx_wr_valid && tx_wr_ready;
    wire [7:0] rx_next   = cfg.bit_order_bit ? {mosi_sync_ff[1], rx_sr_ff[7:1]}
                                             : {rx_sr_ff[6:0], mosi_sync_ff[1]};
    wire       push_rx   = char_done && !rx_full;
    wire       overrun   = char_done && rx_full;
    wire       pop_rx    = rx_rd_en && (rx_cnt_ff != 3'h0);
    wire [2:0] nxt_tx_cnt = tx_cnt_ff + {2'h0, push_tx} - {2'h0, pop_tx};
    wire [2:0] nxt_rx_cnt = rx_cnt_ff + {2'h0, push_rx} - {2'h0, pop_rx};

    ////////////////////////////////////////////////////////////////////////////////
    // shift registers and pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= 3'h0;
            tx_sr_ff   <= spi_slave_pkg::SR_RESET;
            rx_sr_ff   <= spi_slave_pkg::SR_RESET;
            last_ff    <= spi_slave_pkg::BUSY_BYTE;
            miso_o     <= 1'b0;
            miso_oe    <= 1'b0;
        end else begin
            miso_oe <= selected;
            if (!selected) begin
                bit_cnt_ff <= 3'h0;
                rx_sr_ff   <= spi_slave_pkg::SR_RESET;
            end else if (sample_e) begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                rx_sr_ff   <= rx_next;
            end
            if (load_e) begin
                tx_sr_ff <= load_byte;
                last_ff  <= load_byte;
                miso_o   <= cfg.bit_order_bit ? load_byte[0] : load_byte[7];
            end else if (tx_shift) begin
                tx_sr_ff <= cfg.bit_order_bit ? {1'b0, tx_sr_ff[7:1]} : {tx_sr_ff[6:0], 1'b0};
                miso_o   <= cfg.bit_order_bit ? tx_sr_ff[1] : tx_sr_ff[6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fifos
    always_ff @(posedge core_clk) begin
        if (push_tx) tx_mem[tx_wptr_ff] <= tx_wr_data;
        if (push_rx) rx_mem[rx_wptr_ff] <= rx_next;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_rptr_ff <= 2'h0;
            tx_wptr_ff <= 2'h0;
            rx_rptr_ff <= 2'h0;
            rx_wptr_ff <= 2'h0;
            tx_cnt_ff  <= 3'h0;
            rx_cnt_ff  <= 3'h0;
            rx_rd_data <= 8'h00;
        end else begin
            tx_cnt_ff <= nxt_tx_cnt;
            rx_cnt_ff <= nxt_rx_cnt;
            if (push_tx) tx_wptr_ff <= tx_wptr_ff + 2'h1;
            if (pop_tx)  tx_rptr_ff <= tx_rptr_ff + 2'h1;
            if (push_rx) rx_wptr_ff <= rx_wptr_ff + 2'h1;
            if (pop_rx) begin
                rx_rptr_ff <= rx_rptr_ff + 2'h1;
                rx_rd_data <= rx_mem[rx_rptr_ff];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status
    spi_slave_pkg::spi_status_t st;
    assign st = spi_status_register;

    wire nxt_idle  = char_done && tx_empty && !pad_pend_ff ? 1'b1
                   : (sample_e && bit_cnt_ff == 3'h0) ? 1'b0 : st.transmit_idle_status;
    wire nxt_free  = (nxt_tx_cnt != spi_slave_pkg::FIFO_FULL_CNT);
    wire nxt_valid = (nxt_rx_cnt != 3'h0);
    wire nxt_ovf   = overrun || (st.receive_overflow_status &&
                     controller_mode_field != spi_slave_pkg::MODE_OFF);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_status_register <= spi_slave_pkg::STATUS_RESET;
            tx_wr_ready         <= 1'b1;
        end else begin
            spi_status_register <= {nxt_idle, nxt_free, nxt_valid, nxt_ovf};
            tx_wr_ready         <= nxt_free;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // padding byte and polarity switch byte
    wire pad_window = selected && (pad_win_ff || st.receive_valid_status);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_q_ff    <= 1'b0;
            fe_pend_ff  <= 1'b0;
            pad_win_ff  <= 1'b0;
            pad_pend_ff <= 1'b0;
        end else begin
            pol_q_ff <= cfg.clock_polarity_bit;
            if (pol_q_ff && !cfg.clock_polarity_bit && controller_mode_field != spi_slave_pkg::MODE_OFF)
                fe_pend_ff <= 1'b1;
            else if (controller_mode_field == spi_slave_pkg::MODE_OFF || (load_e && fe_pend_ff))
                fe_pend_ff <= 1'b0;
            pad_win_ff <= pad_window;
            if (pad_window && tx_empty && push_tx)
                pad_pend_ff <= 1'b1;
            else if (!selected || (load_e && !fe_pend_ff))
                pad_pend_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // dma error indications and completion detect
    logic [1:0] tx_act_q_ff, rx_act_q_ff;
    logic       rx_ovf_seen_ff;
    wire        tx_dma_done = |(tx_act_q_ff & ~tx_buffer_active_bits);
    wire        rx_dma_done = |(rx_act_q_ff & ~rx_buffer_active_bits);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_act_q_ff    <= 2'h0;
            rx_act_q_ff    <= 2'h0;
            rx_ovf_seen_ff <= 1'b0;
            rx_dma_error   <= 1'b0;
            tx_dma_error   <= 1'b0;
        end else begin
            tx_act_q_ff    <= tx_buffer_active_bits;
            rx_act_q_ff    <= rx_buffer_active_bits;
            rx_ovf_seen_ff <= overrun || (rx_ovf_seen_ff && rx_cnt_ff != 3'h0);
            if (rx_ovf_seen_ff && rx_cnt_ff == 3'h0)
                rx_dma_error <= 1'b1;
            else if (dma_channel_reset_bits[1] || rx_buffer_reload)
                rx_dma_error <= 1'b0;
            if (underrun && |tx_buffer_active_bits)
                tx_dma_error <= 1'b1;
            else if (dma_channel_reset_bits[0] || tx_buffer_reload)
                tx_dma_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt flags and output
    spi_slave_pkg::irq_vec_t ev;
    assign ev = {nxt_idle && !st.transmit_idle_status,
                 nxt_free && !st.transmit_free_status,
                 nxt_valid && !st.receive_valid_status,
                 overrun, underrun, tx_dma_done, rx_dma_done};

    wire irq_any = |(controller_irq_flag_register & controller_irq_mask_register);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            controller_irq_flag_register <= spi_slave_pkg::IRQ_NONE;
            irq                          <= 1'b0;
        end else begin
            // a new event wins over a clear in the same cycle
            controller_irq_flag_register <= (controller_irq_flag_register & ~irq_flag_clear) | ev;
            irq                          <= irq_any && top_irq_mask_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_overrun;
        char_done && rx_full;
    endsequence

    sequence s_overrun_seen;
        rx_wptr_ff == $past(rx_wptr_ff) && controller_irq_flag_register.receive_overrun_irq_flag
            && spi_status_register.receive_overflow_status;
    endsequence

    sequence s_pad_armed;
        pad_window && tx_empty && push_tx;
    endsequence

    AST_MODE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        controller_mode_field != spi_slave_pkg::MODE_SPI |=> !miso_oe)
        else $error("miso driven outside spi mode");

    AST_MASTER_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg.master_select_bit |=> !miso_oe)
        else $error("slave drives miso with master select set");

    AST_CHAR_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        char_done && selected |=> bit_cnt_ff == 3'h0)
        else $error("bit count did not wrap after eight bits");

    AST_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ssn_sync_ff[1]) |=> (bit_cnt_ff == 3'h0) && !miso_oe)
        else $error("deselect did not reset shifter");

    AST_OVERRUN: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_overrun |=> s_overrun_seen)
        else $error("overrun not flagged or character kept");

    AST_RX_VALID: assert property (@(posedge core_clk) disable iff (!rst_n)
        spi_status_register.receive_valid_status == (rx_cnt_ff != 3'h0))
        else $error("receive valid disagrees with fifo level");

    AST_UNDERRUN: assert property (@(posedge core_clk) disable iff (!rst_n)
        underrun |=> controller_irq_flag_register.transmit_underrun_irq_flag)
        else $error("underrun flag not raised");

    AST_BUSY_BYTE: assert property (@(posedge core_clk) disable iff (!rst_n)
        underrun && !cfg.repeat_select_bit |=> tx_sr_ff == spi_slave_pkg::BUSY_BYTE)
        else $error("busy byte not loaded on underrun");

    AST_TX_FREE: assert property (@(posedge core_clk) disable iff (!rst_n)
        tx_cnt_ff == spi_slave_pkg::FIFO_FULL_CNT |-> !spi_status_register.transmit_free_status && !tx_wr_ready)
        else $error("transmit free set while fifo full");

    AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq |-> $past(top_irq_mask_bit) && $past(irq_any))
        else $error("interrupt without both masks");

    AST_RX_DMA_ERR: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rx_dma_error) |-> $past(rx_cnt_ff) == 3'h0)
        else $error("dma error raised before fifo drained");

    AST_POL_SWAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_e && fe_pend_ff |=> tx_sr_ff == spi_slave_pkg::POL_SWAP_BYTE)
        else $error("polarity switch byte not loaded");

    AST_PAD_ARM: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_pad_armed |=> pad_pend_ff)
        else $error("padding byte not armed");

    AST_PAD_UNDERRUN: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_e && pad_pend_ff && !fe_pend_ff |=> controller_irq_flag_register.transmit_underrun_irq_flag)
        else $error("padding byte did not flag underrun");

    AST_PUSH_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        push_tx && tx_empty && !sample_e && !load_e
            |=> $stable({spi_status_register.transmit_idle_status, spi_status_register.transmit_free_status}))
        else $error("push into empty fifo changed status");

    AST_IDLE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        char_done && tx_empty && !pad_pend_ff |=> spi_status_register.transmit_idle_status)
        else $error("transmit idle not set at end of last byte");

    AST_TX_DMA_DONE: assert property (@(posedge core_clk) disable iff (!rst_n)
        tx_dma_done |=> controller_irq_flag_register.tx_dma_done_irq_flag)
        else $error("transmit dma completion not flagged");

endmodule // spi_slave_serial_controller

// ==== tb/spi_master_model.sv ====
// external spi master: drives serial clock, select and mosi, captures miso
`timescale 1ns/1ns
module spi_master_model (
    // clock and frame format
    input  wire logic core_clk,
    input  wire logic cpol,
    input  wire logic cpha,
    input  wire logic lsb,
    // spi pins
    input  wire logic miso_o,
    input  wire logic miso_oe,
    output logic      sclk,
    output logic      ssn,
    output logic      mosi
);
    logic [7:0] mo [8];
    logic [7:0] mi [8];
    initial {sclk, ssn, mosi} = 3'h2;
    // four core cycles per phase: an 80 ns serial clock period
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask
    task automatic frame(input int n);
        logic [2:0] k;
        sclk = cpol;
        half();
        ssn = 1'b0;
        repeat (2) half();
        for (int b = 0; b < n; b++) begin
            for (int i = 0; i < 8; i++) begin
                k = lsb ? 3'(i) : 3'(7 - i);
                if (!cpha) mosi = mo[b][k];
                half();
                sclk = ~cpol;
                if (cpha) mosi = mo[b][k];
                else mi[b][k] = miso_oe ? miso_o : 1'bx;
                half();
                sclk = cpol;
                if (cpha) mi[b][k] = miso_oe ? miso_o : 1'bx;
            end
            repeat (2) half();
        end
        ssn = 1'b1;
        // released data line must not keep showing the last bit
        mosi = ~mosi;
        half();
    endtask
endmodule // spi_master_model

// ==== tb/testbench.sv ====
// self-checking bench for the spi slave serial controller
`timescale 1ns/1ns
module testbench;
    logic                       core_clk, rst_n, top_irq_mask_bit, tx_wr_valid, tx_wr_ready, rx_rd_en, irq;
    logic                       tx_buffer_reload, rx_buffer_reload, tx_dma_error, rx_dma_error;
    logic                       serial_clock_pin, slave_select_n, mosi, miso_o, miso_oe;
    logic [1:0]                 controller_mode_field, dma_channel_reset_bits, tx_act, rx_act;
    logic [7:0]                 tx_wr_data, rx_rd_data, last;
    spi_slave_pkg::spi_cfg_t    cfg;
    spi_slave_pkg::irq_vec_t    irq_mask, irq_clr, flags, flags_q;
    spi_slave_pkg::spi_status_t stat, stat_q;
    int                         n_errors, cmp_count, seed, m;
    logic [7:0]                 txq[$], rxq[$];

    spi_slave_serial_controller i_dut (.core_clk, .rst_n, .controller_mode_field, .spi_config_register(cfg),
        .controller_irq_mask_register(irq_mask), .top_irq_mask_bit, .irq_flag_clear(irq_clr), .tx_wr_valid,
        .tx_wr_data, .tx_wr_ready, .rx_rd_en, .rx_rd_data, .dma_channel_reset_bits, .tx_buffer_active_bits(tx_act),
        .rx_buffer_active_bits(rx_act), .tx_buffer_reload, .rx_buffer_reload, .tx_dma_error, .rx_dma_error,
        .spi_status_register(stat), .controller_irq_flag_register(flags), .irq, .serial_clock_pin,
        .slave_select_n, .mosi, .miso_o, .miso_oe);
    spi_master_model i_master (.core_clk, .cpol(cfg.clock_polarity_bit), .cpha(cfg.clock_phase_bit),
        .lsb(cfg.bit_order_bit), .miso_o, .miso_oe, .sclk(serial_clock_pin), .ssn(slave_select_n), .mosi);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic push(input logic [7:0] b);
        tx_wr_valid = 1'b1;
        tx_wr_data = b;
        cyc(1);
        tx_wr_valid = 1'b0;
        cyc(1);
        txq.push_back(b);
    endtask
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) i_master.mo[i] = 8'($random(seed));
    endtask
    // reference model: fifo byte, else the underrun filler; receive fifo capped at four
    task automatic cmp(input int n);
        logic [7:0] e;
        cyc(4);
        for (int i = 0; i < n; i++) begin
            e = txq.size() != 0 ? txq.pop_front() : (cfg.repeat_select_bit ? last : 8'hff);
            last = e;
            check(i_master.mi[i], e, "miso byte");
            if (rxq.size() < 4) rxq.push_back(i_master.mo[i]);
        end
        check(8'(stat.receive_valid_status), 8'(rxq.size() != 0), "rx valid");
        check(8'(miso_oe), 8'h00, "miso driven while deselected");
    endtask
    task automatic xfer(input int n);
        fill(n);
        i_master.frame(n);
        cmp(n);
    endtask
    task automatic pop_all();
        while (rxq.size() != 0) begin
            rx_rd_en = 1'b1;
            cyc(1);
            rx_rd_en = 1'b0;
            check(rx_rd_data, rxq.pop_front(), "rx byte");
            cyc(1);
        end
        check(8'(stat.receive_valid_status), 8'h00, "rx valid after drain");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        cyc(60000);
        n_errors++;
        $display("[FAIL] %0t run timeout", $time);
        results();
    end
    initial begin
        seed = 78745;
        {rst_n, tx_wr_valid, rx_rd_en, tx_buffer_reload, rx_buffer_reload, top_irq_mask_bit} = 6'h01;
        {controller_mode_field, dma_channel_reset_bits, tx_act, rx_act} = 8'h80;
        {cfg, irq_clr, tx_wr_data, last} = '0;
        irq_mask = '1;
        cyc(20);
        rst_n = 1'b1;
        cyc(1);
        check(8'(stat), 8'(spi_slave_pkg::STATUS_RESET), "reset status");
        check(8'(tx_wr_ready), 8'h01, "reset ready");
        cyc(1);
        // every polarity, phase and bit order, polarity never falling here
        for (m = 0; m < 8; m++) begin
            cfg = spi_slave_pkg::spi_cfg_t'({1'b0, 3'(m), 1'b0});
            cyc(2);
            push(8'($random(seed)));
            push(8'($random(seed)));
            xfer(2);
            pop_all();
        end
        cfg = '0;
        push(8'($random(seed)));
        txq.push_front(8'hfe);
        xfer(2);
        pop_all();
        cfg.repeat_select_bit = 1'b1;
        for (m = 0; m < 4; m++) push(8'($random(seed)));
        check(8'({tx_wr_ready, stat.transmit_free_status}), 8'h00, "tx full");
        xfer(5);
        check(8'({stat.receive_overflow_status, flags.receive_overrun_irq_flag, rx_dma_error}), 8'h06, "overrun");
        check(8'({stat.transmit_free_status, stat.transmit_idle_status}), 8'h03, "tx drained");
        pop_all();
        check(8'(rx_dma_error), 8'h01, "rx dma error after drain");
        rx_buffer_reload = 1'b1;
        cyc(1);
        rx_buffer_reload = 1'b0;
        check(8'(rx_dma_error), 8'h00, "rx dma error reload");
        controller_mode_field = spi_slave_pkg::MODE_OFF;
        cyc(2);
        check(8'(stat.receive_overflow_status), 8'h00, "overflow cleared");
        // spi off, then master select: the pins must be ignored
        for (m = 0; m < 2; m++) begin
            controller_mode_field = m == 0 ? spi_slave_pkg::MODE_OFF : spi_slave_pkg::MODE_SPI;
            cfg = spi_slave_pkg::spi_cfg_t'({m == 1, 4'h0});
            fill(1);
            i_master.frame(1);
            check(i_master.mi[0], 8'hxx, "miso undriven");
            check(8'({stat.receive_valid_status, miso_oe}), 8'h00, "inactive mode");
        end
        cfg = '0;
        txq.delete();
        rxq.delete();
        top_irq_mask_bit = 1'b0;
        cyc(3);
        check(8'(irq), 8'h00, "top mask");
        {top_irq_mask_bit, irq_mask} = 8'h80;
        cyc(3);
        check(8'(irq), 8'h00, "controller mask");
        irq_mask = '1;
        top_irq_mask_bit = 1'b1;
        cyc(3);
        check(8'({irq, flags.receive_valid_irq_flag, flags.transmit_idle_irq_flag}), 8'h07, "irq");
        irq_clr = '1;
        cyc(1);
        irq_clr = '0;
        cyc(3);
        check(8'({flags, irq}), 8'h00, "flags cleared");
        // padding byte when data lands in an empty fifo mid-selection
        tx_act = 2'h1;
        rx_act = 2'h3;
        fill(4);
        fork
            i_master.frame(4);
            begin
                for (m = 0; m < 400 && stat.receive_valid_status !== 1'b1; m++) cyc(1);
                check(8'(m < 400), 8'h01, "rx valid wait");
                {stat_q, flags_q} = {stat, flags};
                push(8'h5a);
                check(8'(stat), 8'(stat_q), "status after push into empty fifo");
                check(8'(flags), 8'(flags_q), "flags after push into empty fifo");
            end
        join
        repeat (3) txq.push_front(8'hff);
        cmp(4);
        check(8'({flags.transmit_underrun_irq_flag, tx_dma_error}), 8'h03, "underrun");
        dma_channel_reset_bits = 2'h1;
        cyc(2);
        check(8'(tx_dma_error), 8'h00, "dma reset");
        {dma_channel_reset_bits, tx_act, rx_act} = 6'h00;
        cyc(3);
        check(8'({flags.tx_dma_done_irq_flag, flags.rx_dma_done_irq_flag}), 8'h03, "dma done");
        pop_all();
        results();
    end
endmodule // testbench
